/* design/lldp_pin_interface.sv */
// low latency dram pin interface: command decode, banks, read and write data paths
`timescale 1ns/1ns
`default_nettype none
`include "lldp_defines.svh"
module lldp_pin_interface
  import lldp_pkg::*;
#(
  parameter int DATA_W = `LLDP_DATA_W,
  parameter int ADDR_W = `LLDP_ADDR_W,
  parameter int MEM_AW = `LLDP_MEM_AW,
  parameter int BURST_LEN = `LLDP_BURST_LEN,
  parameter int RD_LAT = `LLDP_RD_LATENCY
) (
  // clock, reset, enable
  input wire logic clk_in,
  input wire logic sys_rst_in,
  input wire logic ce_in,
  // command and address
  input wire lldp_cmd_t cmd_in,
  input wire logic [ADDR_W-1:0] addr_in,
  input wire logic [`LLDP_BANK_W-1:0] bank_in,
  // write data
  input wire logic [((DATA_W == 36) ? 2 : 1)-1:0] write_data_clk_in,
  input wire logic [((DATA_W == 36) ? 2 : 1)-1:0] write_data_clk_n_in,
  input wire logic [DATA_W-1:0] write_data_in,
  input wire logic write_mask_in,
  // read data
  output logic [((DATA_W == 9) ? 1 : 2)-1:0] read_data_clk_out,
  output logic [((DATA_W == 9) ? 1 : 2)-1:0] read_data_clk_n_out,
  output logic [DATA_W-1:0] read_data_out,
  output logic read_valid_out,
  // status
  output logic refresh_out,
  output logic cmd_error_out,
  output logic [ADDR_W-1:0] mode_value_out,
  // boundary scan
  input wire logic tck_in,
  input wire logic tms_in,
  input wire logic tdi_in,
  output logic tdo_out
);

  localparam int RD_PAIRS = (DATA_W == 9) ? 1 : 2;
  localparam int WR_PAIRS = (DATA_W == 36) ? 2 : 1;
  localparam int WR_LANES = DATA_W / WR_PAIRS;
  localparam int BEAT_W = $clog2(BURST_LEN) + 1;
  localparam int CNT_W = 5;
  localparam int SCAN_W = `LLDP_SCAN_W;
  localparam int MEM_IW = `LLDP_BANK_W + MEM_AW;
  localparam int RD_LO = 2 * RD_LAT - 3;
  localparam int RD_HI = 2 * RD_LAT + 1;
  localparam logic [BEAT_W-1:0] LAST_BEAT = BEAT_W'(BURST_LEN - 1);
  localparam logic [BEAT_W-1:0] LAST_PAIR = BEAT_W'(BURST_LEN - 2);
  // read clock runs at half clk_in, so one read-clock cycle is two clk_in cycles
  localparam logic [CNT_W-1:0] WAIT_CYC = CNT_W'(2 * RD_LAT - 3);

  typedef struct packed {
    logic [WR_PAIRS-1:0] tg_s1;
    logic [WR_PAIRS-1:0] tg_s2;
    logic [WR_PAIRS-1:0] tg_s3;
    logic [WR_PAIRS-1:0] tg_seen;
    logic wr_busy;
    logic [`LLDP_BANK_W-1:0] wr_bank;
    logic [MEM_AW-1:0] wr_addr;
    logic [BEAT_W-1:0] wr_beat;
    lldp_rd_state_t rd_state;
    logic [CNT_W-1:0] rd_cnt;
    logic [`LLDP_BANK_W-1:0] rd_bank;
    logic [MEM_AW-1:0] rd_addr;
    logic [BEAT_W-1:0] rd_beat;
    logic [RD_PAIRS-1:0] rd_clk;
    logic [RD_PAIRS-1:0] rd_clk_n;
    logic [DATA_W-1:0] rd_data;
    logic rd_valid;
    logic refresh;
    logic cmd_error;
    logic [ADDR_W-1:0] mode;
    logic [2:0] tck_s;
    logic [1:0] tms_s;
    logic [1:0] tdi_s;
    lldp_tap_state_t tap;
    logic [SCAN_W-1:0] scan;
    logic tdo;
  } st_t;

  st_t st_q;
  st_t st_d;
  lldp_op_t op;
  logic [DATA_W-1:0] mem [2**MEM_IW];
  logic mem_we;
  logic [MEM_IW-1:0] wi0;
  logic [MEM_IW-1:0] wi1;
  logic [DATA_W-1:0] wd0;
  logic [DATA_W-1:0] wd1;
  logic wm0;
  logic wm1;
  logic [2*WR_LANES+1:0] cap_pair [WR_PAIRS];
  logic [WR_PAIRS-1:0] cap_toggle;
  logic [DATA_W-1:0] rise_data;
  logic [DATA_W-1:0] fall_data;
  logic [WR_PAIRS-1:0] new_pair;
  logic [WR_PAIRS-1:0] seen;
  logic tck_rise;
  logic tck_fall;

  // ***************************************************************
  // write capture, one instance per write clock pair
  // ***************************************************************
  // lanes split evenly over the pairs; the mask is taken from pair zero
  for (genvar g = 0; g < WR_PAIRS; g++) begin : g_wr
    lldp_wr_capture #(.LANES(WR_LANES)) u_cap (
      .wr_clk_in(write_data_clk_in[g]),
      .wr_clk_n_in(write_data_clk_n_in[g]),
      .sys_rst_in(sys_rst_in),
      .data_in(write_data_in[g*WR_LANES +: WR_LANES]),
      .mask_in(write_mask_in),
      .pair_out(cap_pair[g]),
      .toggle_out(cap_toggle[g])
    );
    assign rise_data[g*WR_LANES +: WR_LANES] = cap_pair[g][WR_LANES-1:0];
    assign fall_data[g*WR_LANES +: WR_LANES] = cap_pair[g][2*WR_LANES:WR_LANES+1];
  end

  assign op = lldp_decode(cmd_in);
  assign new_pair = st_q.tg_s2 ^ st_q.tg_s3;
  assign seen = st_q.tg_seen | new_pair;
  assign tck_rise = st_q.tck_s[1] & ~st_q.tck_s[2];
  assign tck_fall = ~st_q.tck_s[1] & st_q.tck_s[2];

  // ***************************************************************
  // next-state logic
  // ***************************************************************
  always_comb begin
    st_d = st_q;
    mem_we = 1'h0;
    wi0 = {st_q.wr_bank, st_q.wr_addr + MEM_AW'(st_q.wr_beat)};
    wi1 = {st_q.wr_bank, st_q.wr_addr + MEM_AW'(st_q.wr_beat) + MEM_AW'(1)};
    wd0 = rise_data;
    wd1 = fall_data;
    wm0 = cap_pair[0][WR_LANES];
    wm1 = cap_pair[0][2*WR_LANES+1];
    if (ce_in) begin
      // crossing of the pair toggles
      st_d.tg_s1 = cap_toggle;
      st_d.tg_s2 = st_q.tg_s1;
      st_d.tg_s3 = st_q.tg_s2;
      st_d.tck_s = {st_q.tck_s[1:0], tck_in};
      st_d.tms_s = {st_q.tms_s[0], tms_in};
      st_d.tdi_s = {st_q.tdi_s[0], tdi_in};

      // command decode
      st_d.refresh = (op == OP_REFRESH);
      // illegal combination only flagged; the controller keeps it away
      st_d.cmd_error = (op == OP_ILLEGAL);
      if (op == OP_MODE) begin
        st_d.mode = addr_in;
      end

      // write path: clock stands still outside bursts, so every pair is data
      if (&seen) begin
        st_d.tg_seen = '0;
        if (st_q.wr_busy) begin
          mem_we = 1'h1;
          if (st_q.wr_beat == LAST_PAIR) begin
            st_d.wr_busy = 1'h0;
          end else begin
            st_d.wr_beat = st_q.wr_beat + BEAT_W'(2);
          end
        end
      end else begin
        st_d.tg_seen = seen;
      end
      if (op == OP_WRITE && !st_q.wr_busy) begin
        st_d.wr_busy = 1'h1;
        st_d.wr_bank = bank_in;
        st_d.wr_addr = addr_in[MEM_AW-1:0];
        st_d.wr_beat = '0;
      end

      // read clocks toggle every cycle, data moves with each edge
      st_d.rd_clk = ~st_q.rd_clk;
      st_d.rd_clk_n = ~st_q.rd_clk_n;
      case (st_q.rd_state)
        RD_IDLE: begin
          if (op == OP_READ) begin
            st_d.rd_state = RD_WAIT;
            st_d.rd_bank = bank_in;
            st_d.rd_addr = addr_in[MEM_AW-1:0];
            st_d.rd_cnt = WAIT_CYC;
          end
        end
        RD_WAIT: begin
          // wait for the edge before a falling read clock so beat zero meets a rise
          if (st_q.rd_cnt == '0) begin
            if (st_q.rd_clk[0]) begin
              st_d.rd_state = RD_LEAD;
              st_d.rd_valid = 1'h1;
            end
          end else begin
            st_d.rd_cnt = st_q.rd_cnt - CNT_W'(1);
          end
        end
        RD_LEAD: begin
          st_d.rd_state = RD_BURST;
          st_d.rd_beat = '0;
          st_d.rd_data = mem[{st_q.rd_bank, st_q.rd_addr}];
          st_d.rd_valid = (LAST_BEAT != '0);
        end
        RD_BURST: begin
          if (st_q.rd_beat == LAST_BEAT) begin
            st_d.rd_state = RD_IDLE;
            st_d.rd_data = '0;
          end else begin
            st_d.rd_beat = st_q.rd_beat + BEAT_W'(1);
            st_d.rd_data = mem[{st_q.rd_bank, st_q.rd_addr + MEM_AW'(st_q.rd_beat + 1'h1)}];
            // drop valid as the last beat starts
            st_d.rd_valid = (st_q.rd_beat + BEAT_W'(1) != LAST_BEAT);
          end
        end
        default: begin
          st_d.rd_state = RD_IDLE;
        end
      endcase

      // boundary scan, sampled by the oversampled test clock
      if (tck_rise) begin
        case (st_q.tap)
          TAP_IDLE: begin
            if (st_q.tms_s[1]) begin
              st_d.tap = TAP_SELECT;
            end
          end
          TAP_SELECT: begin
            if (st_q.tms_s[1]) begin
              st_d.tap = TAP_IDLE;
            end else begin
              st_d.tap = TAP_SHIFT;
              st_d.scan = {cmd_in.sel_n, cmd_in.ref_n, cmd_in.we_n, bank_in};
            end
          end
          TAP_SHIFT: begin
            st_d.scan = {st_q.tdi_s[1], st_q.scan[SCAN_W-1:1]};
            if (st_q.tms_s[1]) begin
              st_d.tap = TAP_EXIT;
            end
          end
          default: begin
            st_d.tap = TAP_IDLE;
          end
        endcase
      end
      if (tck_fall) begin
        st_d.tdo = st_q.scan[0];
      end
    end
    if (sys_rst_in) begin
      st_d = '0;
      st_d.rd_state = RD_IDLE;
      st_d.tap = TAP_IDLE;
      st_d.mode = `LLDP_MODE_RST;
      st_d.rd_clk = {RD_PAIRS{`LLDP_RD_CLK_RST}};
      st_d.rd_clk_n = {RD_PAIRS{`LLDP_RD_CLK_N_RST}};
      mem_we = 1'h0;
    end
  end

  always_ff @(posedge clk_in) begin
    st_q <= st_d;
  end

  // masked beats are not stored
  always_ff @(posedge clk_in) begin
    if (mem_we) begin
      if (!wm0) begin
        mem[wi0] <= wd0;
      end
      if (!wm1) begin
        mem[wi1] <= wd1;
      end
    end
  end

  assign read_data_clk_out = st_q.rd_clk;
  assign read_data_clk_n_out = st_q.rd_clk_n;
  assign read_data_out = st_q.rd_data;
  assign read_valid_out = st_q.rd_valid;
  assign refresh_out = st_q.refresh;
  assign cmd_error_out = st_q.cmd_error;
  assign mode_value_out = st_q.mode;
  assign tdo_out = st_q.tdo;

  // ***************************************************************
  // checks
  // ***************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (sys_rst_in || !ce_in);

  sequence s_valid_lead;
    $rose(read_valid_out) ##0 !read_data_clk_out[0];
  endsequence

  sequence s_first_beat;
    read_data_clk_out[0] && st_q.rd_state == RD_BURST && st_q.rd_beat == '0;
  endsequence

  chk_refresh_decode:
    assert property (!cmd_in.sel_n && !cmd_in.ref_n && cmd_in.we_n && !cmd_in.mode_set
                     |=> refresh_out && !cmd_error_out)
    else $error("refresh command not decoded");

  chk_deselect_nop:
    assert property (cmd_in.sel_n && st_q.rd_state == RD_IDLE
                     |=> !refresh_out && !cmd_error_out && st_q.rd_state == RD_IDLE
                         && $stable(mode_value_out))
    else $error("deselected cycle acted on a command");

  chk_mode_load:
    assert property (!cmd_in.sel_n && cmd_in.mode_set |=> mode_value_out == $past(addr_in))
    else $error("mode register not loaded from address pins");

  chk_write_bank:
    assert property (op == OP_WRITE && !st_q.wr_busy
                     |=> st_q.wr_busy && st_q.wr_bank == $past(bank_in)
                         && st_q.wr_addr == $past(addr_in[MEM_AW-1:0]))
    else $error("write bank or address not captured");

  chk_read_start:
    assert property (op == OP_READ && st_q.rd_state == RD_IDLE
                     |=> st_q.rd_state == RD_WAIT && st_q.rd_bank == $past(bank_in))
    else $error("read command not accepted");

  chk_rd_clk_pair:
    // no toggle is owed on the edge after reset or after a frozen cycle
    assert property (read_data_clk_n_out == ~read_data_clk_out
                     && ($past(sys_rst_in) || !$past(ce_in)
                         || read_data_clk_out != $past(read_data_clk_out)))
    else $error("read clock pair not complementary or not toggling");

  chk_valid_lead:
    assert property (s_valid_lead |=> s_first_beat)
    else $error("read valid did not lead first beat by half a cycle");

  chk_valid_drop:
    assert property ($fell(read_valid_out) |-> st_q.rd_state == RD_BURST
                     && st_q.rd_beat == LAST_BEAT)
    else $error("read valid did not drop as last beat started");

  chk_read_latency:
    assert property (op == OP_READ && st_q.rd_state == RD_IDLE
                     |-> ##[RD_LO:RD_HI] $rose(read_valid_out))
    else $error("read latency out of range");

  chk_store_beat:
    assert property (mem_we && !wm0 |=> mem[$past(wi0)] == $past(wd0))
    else $error("unmasked beat not stored");

  chk_tms_sample:
    assert property (tck_rise && st_q.tap == TAP_IDLE && st_q.tms_s[1]
                     |=> st_q.tap == TAP_SELECT)
    else $error("mode select not sampled on rising test clock");

  chk_tdo_launch:
    assert property (tck_fall |=> tdo_out == $past(st_q.scan[0]))
    else $error("test data output not launched on falling test clock");

endmodule
`default_nettype wire

/* design/lldp_defines.svh */
// constants of the low latency dram pin interface
`ifndef LLDP_DEFINES_SVH
`define LLDP_DEFINES_SVH

// ***************************************************************
// widths and sizes
// ***************************************************************
`define LLDP_DATA_W 18
`define LLDP_ADDR_W 20
`define LLDP_MEM_AW 4
`define LLDP_BANK_W 3
`define LLDP_SCAN_W 6

// ***************************************************************
// timing counts, in read-clock cycles or beats
// ***************************************************************
`define LLDP_BURST_LEN 2
`define LLDP_RD_LATENCY 4

// ***************************************************************
// reset values
// ***************************************************************
`define LLDP_MODE_RST 20'h0_0000
`define LLDP_RD_CLK_RST 1'h0
`define LLDP_RD_CLK_N_RST 1'h1

`endif

/* design/lldp_pkg.sv */
// types shared by the low latency dram pin interface
package lldp_pkg;

  // ***************************************************************
  // command pins
  // ***************************************************************
  typedef struct packed {
    logic sel_n;
    logic ref_n;
    logic we_n;
    logic mode_set;
  } lldp_cmd_t;

  typedef enum logic [2:0] {
    OP_NOP = 3'h0,
    OP_READ = 3'h1,
    OP_WRITE = 3'h2,
    OP_REFRESH = 3'h3,
    OP_MODE = 3'h4,
    OP_ILLEGAL = 3'h5
  } lldp_op_t;

  // ***************************************************************
  // state machines
  // ***************************************************************
  typedef enum logic [1:0] {
    RD_IDLE = 2'h0,
    RD_WAIT = 2'h1,
    RD_LEAD = 2'h3,
    RD_BURST = 2'h2
  } lldp_rd_state_t;

  typedef enum logic [1:0] {
    TAP_IDLE = 2'h0,
    TAP_SELECT = 2'h1,
    TAP_SHIFT = 2'h3,
    TAP_EXIT = 2'h2
  } lldp_tap_state_t;

  // deselected cycles decode as no operation
  function automatic lldp_op_t lldp_decode(input lldp_cmd_t c);
    lldp_op_t op;
    op = OP_NOP;
    if (!c.sel_n) begin
      if (c.mode_set) begin
        op = OP_MODE;
      end else begin
        case ({c.ref_n, c.we_n})
          2'h1: op = OP_REFRESH;
          2'h2: op = OP_WRITE;
          2'h3: op = OP_READ;
          default: op = OP_ILLEGAL;
        endcase
      end
    end
    return op;
  endfunction

endpackage

/* design/lldp_wr_capture.sv */
// write-data capture of one write clock pair, with event toggle for the crossing
`timescale 1ns/1ns
`default_nettype none
module lldp_wr_capture
  import lldp_pkg::*;
#(
  parameter int LANES = 18
) (
  // write clock pair
  input wire logic wr_clk_in,
  input wire logic wr_clk_n_in,
  // reset from the system domain
  input wire logic sys_rst_in,
  // lanes and mask
  input wire logic [LANES-1:0] data_in,
  input wire logic mask_in,
  // beat pair and event toggle
  output logic [2*LANES+1:0] pair_out,
  output logic toggle_out
);

  typedef struct packed {
    logic rst_s1;
    logic rst_s2;
    logic [LANES-1:0] data_r;
    logic mask_r;
  } rise_t;

  typedef struct packed {
    logic [2*LANES+1:0] pair;
    logic toggle;
  } fall_t;

  rise_t r_q;
  rise_t r_d;
  fall_t f_q;
  fall_t f_d;

  // ***************************************************************
  // first beat at the rising edge of the true clock
  // ***************************************************************
  always_comb begin
    r_d = r_q;
    r_d.rst_s1 = sys_rst_in;
    r_d.rst_s2 = r_q.rst_s1;
    r_d.data_r = data_in;
    r_d.mask_r = mask_in;
  end

  always_ff @(posedge wr_clk_in) begin
    r_q <= r_d;
  end

  // ***************************************************************
  // second beat at the rising edge of the complement
  // ***************************************************************
  // pair is held until the next pair, long enough for the slow side
  always_comb begin
    f_d = f_q;
    if (r_q.rst_s2) begin
      f_d.pair = '0;
      f_d.toggle = 1'h0;
    end else begin
      f_d.pair = {mask_in, data_in, r_q.mask_r, r_q.data_r};
      f_d.toggle = ~f_q.toggle;
    end
  end

  always_ff @(posedge wr_clk_n_in) begin
    f_q <= f_d;
  end

  assign pair_out = f_q.pair;
  assign toggle_out = f_q.toggle;

endmodule
`default_nettype wire

/* dv/lldp_ctl_model.sv */
// memory controller model: commands, addresses and write bursts
`timescale 1ns/1ns
`default_nettype none
module lldp_ctl_model
  import lldp_pkg::*;
(
  // clock
  input wire logic clk_in,
  // command side
  output lldp_cmd_t cmd_out,
  output logic [19:0] addr_out,
  output logic [2:0] bank_out,
  // write side
  output logic wclk_out,
  output logic wclk_n_out,
  output logic [17:0] wdata_out,
  output logic wmask_out
);
  // ****************************************
  // pins
  // ****************************************
  initial begin
    cmd_out = 4'hE;
    addr_out = 20'h0_0000;
    bank_out = 3'h0;
    wclk_out = 1'b0;
    wclk_n_out = 1'b1;
    wdata_out = 18'h0_0000;
    wmask_out = 1'b1;
  end

  // one command cycle; released command pins return to deselect, address and bank pins show the inverse
  task automatic issue(input logic [3:0] c, input logic [19:0] a, input logic [2:0] b);
    @(posedge clk_in) #1;
    cmd_out = c;
    addr_out = a;
    bank_out = b;
    @(posedge clk_in) #1;
    cmd_out = 4'hE;
    addr_out = ~a;
    bank_out = ~b;
  endtask

  // one beat pair; clock stands still outside bursts
  task automatic burst(input logic [17:0] d0, input logic [17:0] d1, input logic m0,
                       input logic m1);
    wdata_out = d0;
    wmask_out = m0;
    #20;
    wclk_out = 1'b1;
    wclk_n_out = 1'b0;
    #42;
    wdata_out = d1;
    wmask_out = m1;
    #20;
    wclk_out = 1'b0;
    wclk_n_out = 1'b1;
    #43;
    wdata_out = ~d1;
    wmask_out = ~m1;
  endtask

  // write-domain reset needs a few clock edges while reset is high
  task automatic prime();
    repeat (3) begin
      #62 wclk_out = 1'b1;
      wclk_n_out = 1'b0;
      #63 wclk_out = 1'b0;
      wclk_n_out = 1'b1;
    end
  endtask
endmodule
`default_nettype wire

/* dv/testbench.sv */
// self-checking bench of the low latency dram pin interface
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import lldp_pkg::*;
  logic clk_in = 1'b0;
  logic sys_rst_in, ce_in, tck, tms, tdi, tdo;
  lldp_cmd_t cmd;
  logic [19:0] addr, m, mode_v;
  logic [2:0] bank, b;
  logic [3:0] a;
  logic wclk, wclk_n, wmask, rvalid, refr, cerr;
  logic [17:0] wdata, rdata;
  logic [1:0] rclk, rclk_n, rc;
  logic [6:0] w;
  logic [17:0] mem [int];
  int mismatches = 0;
  int n_tests = 0;

  always #5 clk_in = ~clk_in;

  lldp_ctl_model ctl_u (.clk_in(clk_in), .cmd_out(cmd), .addr_out(addr), .bank_out(bank),
    .wclk_out(wclk), .wclk_n_out(wclk_n), .wdata_out(wdata), .wmask_out(wmask));

  lldp_pin_interface dut_u (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .ce_in(ce_in),
    .cmd_in(cmd), .addr_in(addr), .bank_in(bank), .write_data_clk_in(wclk),
    .write_data_clk_n_in(wclk_n), .write_data_in(wdata), .write_mask_in(wmask),
    .read_data_clk_out(rclk), .read_data_clk_n_out(rclk_n), .read_data_out(rdata),
    .read_valid_out(rvalid), .refresh_out(refr), .cmd_error_out(cerr),
    .mode_value_out(mode_v), .tck_in(tck), .tms_in(tms), .tdi_in(tdi), .tdo_out(tdo));

  // ****************************************
  // compare and verdict
  // ****************************************
  task automatic cmp_bit(input string what, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic cmp_vec(input string what, input logic [19:0] exp, input logic [19:0] got);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // read clocks checked every cycle once out of reset
  always @(posedge clk_in) begin
    #1;
    if (sys_rst_in === 1'b0) begin
      cmp_bit("read clock pair", ~rclk[0], rclk_n[0]);
      cmp_bit("read clock lanes", rclk[0], rclk[1]);
    end
  end

  // ****************************************
  // operations
  // ****************************************
  task automatic pulse(input logic [3:0] c, input logic er, input logic ee);
    ctl_u.issue(c, 20'($urandom), 3'($urandom));
    cmp_bit("refresh pulse", er, refr);
    cmp_bit("error pulse", ee, cerr);
    @(posedge clk_in) #1;
    cmp_bit("refresh end", 1'b0, refr);
  endtask

  task automatic wr(input logic [2:0] bk, input logic [3:0] ad, input logic m0, input logic m1);
    logic [17:0] d0, d1;
    d0 = 18'($urandom);
    d1 = 18'($urandom);
    ctl_u.issue(4'h4, {16'($urandom), ad}, bk);
    ctl_u.burst(d0, d1, m0, m1);
    if (!m0) mem[{bk, ad}] = d0;
    if (!m1) mem[{bk, ad + 4'h1}] = d1;
    repeat (8) @(posedge clk_in);
    #1;
  endtask

  task automatic rd(input logic [2:0] bk, input logic [3:0] ad);
    int k;
    ctl_u.issue(4'h6, {16'($urandom), ad}, bk);
    k = 0;
    while (rvalid !== 1'b1 && k < 12) begin
      @(posedge clk_in) #1;
      k++;
    end
    cmp_bit("read latency", 1'b1, k >= 6 && k <= 7);
    @(posedge clk_in) #1;
    cmp_bit("valid at beat 0", 1'b1, rvalid);
    cmp_bit("clock at beat 0", 1'b1, rclk[0]);
    cmp_vec("beat 0", {2'h0, mem[{bk, ad}]}, {2'h0, rdata});
    @(posedge clk_in) #1;
    cmp_bit("valid at beat 1", 1'b0, rvalid);
    cmp_vec("beat 1", {2'h0, mem[{bk, ad + 4'h1}]}, {2'h0, rdata});
    @(posedge clk_in) #1;
    cmp_vec("idle data", 20'h0_0000, {2'h0, rdata});
  endtask

  // tck low and high 100 ns each, far slower than the sync allows
  task automatic tck_cycle(input logic s, input logic d);
    tms = s;
    tdi = d;
    #50 tck = 1'b1;
    #100 tck = 1'b0;
    #50;
  endtask

  // ****************************************
  // tests
  // ****************************************
  initial begin
    sys_rst_in = 1'b1;
    ce_in = 1'b1;
    tck = 1'b0;
    tms = 1'b0;
    tdi = 1'b0;
    void'($urandom(20));
    repeat (2) @(posedge clk_in);
    ctl_u.prime();
    @(posedge clk_in) #1;
    sys_rst_in = 1'b0;
    // write-domain reset sync only clears on write clock edges after release
    ctl_u.prime();
    pulse(4'h2, 1'b1, 1'b0);
    pulse(4'hA, 1'b0, 1'b0);
    pulse(4'h0, 1'b0, 1'b1);
    $display("test commands done");
    m = 20'($urandom);
    ctl_u.issue(4'h1, m, 3'h0);
    cmp_vec("mode value", m, mode_v);
    ctl_u.issue(4'h9, ~m, 3'h0);
    cmp_vec("mode kept", m, mode_v);
    $display("test mode done");
    @(posedge clk_in) #1;
    ce_in = 1'b0;
    rc = rclk;
    repeat (3) @(posedge clk_in);
    #1;
    cmp_vec("frozen read clock", {18'h0_0000, rc}, {18'h0_0000, rclk});
    ce_in = 1'b1;
    @(posedge clk_in) #1;
    cmp_vec("resumed read clock", {18'h0_0000, ~rc}, {18'h0_0000, rclk});
    $display("test enable done");
    for (int i = 0; i < 8; i++) begin
      b = 3'(i);
      a = 4'($urandom);
      wr(b, a, 1'b0, 1'b0);
      wr(b, a, i[0], i[1]);
      rd(b, a);
    end
    ctl_u.burst(18'($urandom), 18'($urandom), 1'b0, 1'b0);
    repeat (8) @(posedge clk_in);
    rd(b, a);
    $display("test data paths done");
    b = 3'($urandom);
    w = 7'($urandom);
    ctl_u.issue(4'hE, 20'h0_0000, b);
    w[5:0] = {3'h7, ~b};
    tck_cycle(1'b1, 1'b0);
    for (int i = 0; i < 7; i++) begin
      tck_cycle(1'b0, (i == 1) ? w[6] : 1'b0);
      cmp_bit("scan out", w[i], tdo);
    end
    $display("test scan done");
    print_verdict();
  end

  initial begin
    #300000;
    mismatches++;
    print_verdict();
  end
endmodule
`default_nettype wire
